//--- logic/tpw_flag.sv
`timescale 1ns/1ns
module tpw_flag (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic nrst,
    // Event and software access.
    input  wire logic set_evt,
    input  wire logic rd_hit,
    input  wire logic wr_hit,
    input  wire logic wr_val,
    // Flag state.
    output logic      flag
);

    logic armed;

    // A read only arms the clear while the flag is seen set; any new event disarms it.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            armed <= 1'b0;
        end else if (set_evt) begin
            armed <= 1'b0; // R6
        end else if (rd_hit && flag) begin
            armed <= 1'b1; // R5
        end else if (wr_hit) begin
            armed <= 1'b0;
        end
    end

    // The event wins over a clearing write in the same cycle so it is never lost.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1; // R25
        end else if (wr_hit && !wr_val && armed) begin
            flag <= 1'b0; // R5
        end
    end

    sequence s_read_set;
        rd_hit && flag && !set_evt;
    endsequence

    sequence s_clear_wr;
        wr_hit && !wr_val && !set_evt;
    endsequence

    AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!nrst) // R25
        set_evt |=> flag)
        else $error("flag not set after event");

    AST_FLAG_TWO_STEP: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
        s_read_set ##1 (!wr_hit && !set_evt)[*2] ##1 s_clear_wr |=> !flag)
        else $error("read then zero write did not clear flag");

    AST_FLAG_NO_READ: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
        (flag && !armed) ##0 s_clear_wr |=> flag)
        else $error("flag cleared without qualifying read");

    AST_FLAG_RESTART: assert property (@(posedge ref_clk) disable iff (!nrst) // R6
        s_read_set ##[1:600] ((!rd_hit) throughout (set_evt ##[1:600] s_clear_wr)) |=> flag)
        else $error("flag cleared although new event came between steps");

endmodule : tpw_flag

//--- logic/tpw_pkg.sv
package tpw_pkg;

    // Register byte addresses; each 8-bit register sits in the low byte of one word.
    localparam logic [11:0] OFS_SC        = 12'h000;
    localparam logic [11:0] OFS_CNTH      = 12'h004;
    localparam logic [11:0] OFS_CNTL      = 12'h008;
    localparam logic [11:0] OFS_MODH      = 12'h00C;
    localparam logic [11:0] OFS_MODL      = 12'h010;
    localparam logic [11:0] OFS_CH_BASE   = 12'h020;
    localparam logic [11:0] OFS_CH_STRIDE = 12'h010;
    localparam logic [1:0]  CH_SUB_SC     = 2'h0;
    localparam logic [1:0]  CH_SUB_VH     = 2'h1;
    localparam logic [1:0]  CH_SUB_VL     = 2'h2;

    // Main status/control fields.
    localparam int SC_FLAG    = 7;
    localparam int SC_IE      = 6;
    localparam int SC_CENTRE_ALIGNED_PWM    = 5;
    localparam int SC_CLKS_LO = 3;
    localparam int SC_PS_LO   = 0;

    // Channel status/control fields.
    localparam int CSC_FLAG   = 7;
    localparam int CSC_IE     = 6;
    localparam int CSC_MS_LO  = 4;
    localparam int CSC_ELS_LO = 2;

    // Reset values and counter landmarks.
    localparam logic [6:0]  SC_CTL_RST  = 7'h00;
    localparam logic [4:0]  CSC_CTL_RST = 5'h00;
    localparam logic [15:0] MOD_RST     = 16'h0000;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [15:0] CNT_TOP     = 16'hFFFF;
    localparam logic [15:0] CNT_PRE_TOP = 16'hFFFE;
    localparam int          NCH_DEF     = 2;

    typedef enum logic [1:0] {
        TPW_CAPTURE,
        TPW_COMPARE,
        TPW_EDGE_PWM,
        TPW_CENTRE_PWM
    } tpw_chmode_e;

    function automatic tpw_chmode_e tpw_chan_mode(input logic centre_aligned_pwm, input logic [1:0] ms);
        if (centre_aligned_pwm) begin
            return TPW_CENTRE_PWM;
        end
        unique case (ms)
            2'h0:    return TPW_CAPTURE;
            2'h1:    return TPW_COMPARE;
            default: return TPW_EDGE_PWM;
        endcase
    endfunction : tpw_chan_mode

endpackage : tpw_pkg

//--- logic/tpw_timer.sv
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
// What this block does
// [R1] Overflow flag on modulo to zero wrap
// [R2] Free-running: overflow flag on FFFF to zero
// [R3] Centre-aligned: overflow flag at top reversal
// [R4] Interrupt level while flag and enable set
// [R5] Flag clears by read-set then write zero
// [R6] Event between steps restarts clear sequence
// [R7] Capture flag on selected edge
// [R8] Compare flag on counter equal value
// [R9] Edge PWM flag at duty end match
// [R10] Centre PWM flag at both matches
// [R11] Counter write clears counter and prescaler
// [R12] Halt reads of counter show live value
// [R13] Halt writes reset counter read latch
// [R14] Halt channel reads live; control write resets
// [R15] Capture mode ignores channel value writes
// [R16] Compare loads buffer at next counter tick
// [R17] PWM loads buffer at modulo minus one step
// [R18] Centre PWM value equal modulo: full duty
// [R19] Centre PWM modulo minus one: near full
// [R20] Zero to non-zero waits new period
// [R21] Non-zero to zero finishes current period
// [R22] Halt control write resets modulo write latch
// [R23] No clock: load on second byte write
// [R24] Channel control write drops pending value
// [R25] Event beats simultaneous clearing write
module tpw_timer
    import tpw_pkg::*;
#(
    parameter int NCH = NCH_DEF
) (
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // APB slave.
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Chip status.
    input  wire logic             background_debug_halt,
    // Channel pins and interrupt.
    input  wire logic [NCH-1:0]   chan_in,
    output logic      [NCH-1:0]   chan_out,
    output logic                  irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic        acc;
    logic        wr;
    logic        rd;
    logic [7:0]  wbyte;
    logic        wr_sc;
    logic        rd_sc;
    logic        wr_cnt;
    logic        rd_cnt;
    logic        wr_modh;
    logic        wr_modl;
    logic        halt;
    logic        mapped;
    logic [NCH-1:0] wr_csc;
    logic [NCH-1:0] rd_csc;
    logic [NCH-1:0] wr_vh;
    logic [NCH-1:0] wr_vl;
    logic [NCH-1:0] rd_cv;
    logic [NCH-1:0] ch_hit;

    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign rd      = acc && !pwrite;
    assign wbyte   = pwdata[7:0];
    assign halt    = background_debug_halt;
    assign wr_sc   = wr && (paddr == OFS_SC);
    assign rd_sc   = rd && (paddr == OFS_SC);
    assign wr_cnt  = wr && ((paddr == OFS_CNTH) || (paddr == OFS_CNTL));
    assign rd_cnt  = rd && ((paddr == OFS_CNTH) || (paddr == OFS_CNTL));
    assign wr_modh = wr && (paddr == OFS_MODH);
    assign wr_modl = wr && (paddr == OFS_MODL);

    for (genvar i = 0; i < NCH; i++) begin : g_dec
        localparam logic [11:0] BASE = 12'(OFS_CH_BASE + i * OFS_CH_STRIDE);
        assign ch_hit[i] = (paddr[11:4] == BASE[11:4]) && (paddr[1:0] == 2'h0)
                           && (paddr[3:2] != 2'h3);
        assign wr_csc[i] = wr && ch_hit[i] && (paddr[3:2] == CH_SUB_SC);
        assign rd_csc[i] = rd && ch_hit[i] && (paddr[3:2] == CH_SUB_SC);
        assign wr_vh[i]  = wr && ch_hit[i] && (paddr[3:2] == CH_SUB_VH);
        assign wr_vl[i]  = wr && ch_hit[i] && (paddr[3:2] == CH_SUB_VL);
        assign rd_cv[i]  = rd && ch_hit[i] && (paddr[3:2] != CH_SUB_SC);
    end

    assign mapped  = (paddr == OFS_SC) || (paddr == OFS_CNTH) || (paddr == OFS_CNTL)
                     || (paddr == OFS_MODH) || (paddr == OFS_MODL) || (|ch_hit);
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    ////////////////////////////////////////////////////////////////////////////////
    // Main control, prescaler and counter.

    logic [6:0]  sc_ctl;
    logic        ovf_ie;
    logic        centre_aligned_pwm;
    logic [1:0]  clks;
    logic [2:0]  ps;
    logic [6:0]  div;
    logic [6:0]  ps_top;
    logic        tick;
    logic [15:0] cnt;
    logic        cnt_up;
    logic        cnt_moved;
    logic [15:0] mod;
    logic        wrap_now;
    logic        rev_now;
    logic        tof_evt;
    logic        ovf_flag;
    logic [15:0] load_pt;
    logic        pwm_load;

    assign ovf_ie   = sc_ctl[SC_IE];
    assign centre_aligned_pwm     = sc_ctl[SC_CENTRE_ALIGNED_PWM];
    assign clks     = sc_ctl[SC_CLKS_LO +: 2];
    assign ps       = sc_ctl[SC_PS_LO +: 3];
    assign ps_top   = 7'((8'h01 << ps) - 8'h01);
    assign tick     = (clks != 2'h0) && !halt && (div == ps_top);
    assign wrap_now = !centre_aligned_pwm && (((mod != MOD_RST) && (cnt == mod)) || (cnt == CNT_TOP));
    assign rev_now  = centre_aligned_pwm && cnt_up && (cnt >= mod);
    assign tof_evt  = tick && (wrap_now || rev_now); // R1 R2 R3
    assign load_pt  = (mod == MOD_RST) ? CNT_PRE_TOP : 16'(mod - 16'h0001);
    assign pwm_load = tick && cnt_up && (cnt == load_pt); // R17

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sc_ctl <= SC_CTL_RST;
        end else if (wr_sc) begin
            sc_ctl <= wbyte[6:0];
        end
    end

    // The divider freezes with the counter while the chip is halted.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div <= 7'h00;
        end else if (wr_cnt || tick || (clks == 2'h0)) begin
            div <= 7'h00; // R11
        end else if (!halt) begin
            div <= 7'(div + 7'h01);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt    <= CNT_ZERO;
            cnt_up <= 1'b1;
        end else if (wr_cnt) begin
            cnt    <= CNT_ZERO; // R11
            cnt_up <= 1'b1;
        end else if (!centre_aligned_pwm) begin
            cnt_up <= 1'b1;
            if (tick) begin
                cnt <= wrap_now ? CNT_ZERO : 16'(cnt + 16'h0001); // R1 R2
            end
        end else if (tick) begin
            if (rev_now) begin
                cnt_up <= 1'b0; // R3
                cnt    <= 16'(cnt - 16'h0001);
            end else if (!cnt_up && (cnt == CNT_ZERO)) begin
                cnt_up <= 1'b1;
                cnt    <= 16'(cnt + 16'h0001);
            end else begin
                cnt    <= cnt_up ? 16'(cnt + 16'h0001) : 16'(cnt - 16'h0001);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_moved <= 1'b0;
        end else begin
            cnt_moved <= tick && !wr_cnt;
        end
    end

    tpw_flag u_ovf_flag (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .set_evt (tof_evt),
        .rd_hit  (rd_sc),
        .wr_hit  (wr_sc),
        .wr_val  (wbyte[SC_FLAG]),
        .flag    (ovf_flag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Modulo pair and counter read coherency.

    logic [15:0] mod_buf;
    logic        mod_hi_w;
    logic        mod_lo_w;
    logic        cnt_lat_v;
    logic [15:0] cnt_lat;
    logic [15:0] cnt_rd;

    // The second byte of either order completes the pair.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mod      <= MOD_RST;
            mod_buf  <= MOD_RST;
            mod_hi_w <= 1'b0;
            mod_lo_w <= 1'b0;
        end else if (wr_sc) begin
            mod_hi_w <= 1'b0; // R22
            mod_lo_w <= 1'b0;
        end else if (wr_modh) begin
            mod_buf[15:8] <= wbyte;
            mod_hi_w      <= !mod_lo_w;
            mod_lo_w      <= 1'b0;
            if (mod_lo_w) begin
                mod <= {wbyte, mod_buf[7:0]};
            end
        end else if (wr_modl) begin
            mod_buf[7:0] <= wbyte;
            mod_lo_w     <= !mod_hi_w;
            mod_hi_w     <= 1'b0;
            if (mod_hi_w) begin
                mod <= {mod_buf[15:8], wbyte};
            end
        end
    end

    // First byte read snapshots the pair; the other byte then comes from the snapshot.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_lat_v <= 1'b0;
            cnt_lat   <= CNT_ZERO;
        end else if (wr_cnt || (wr_sc && halt)) begin
            cnt_lat_v <= 1'b0; // R13
        end else if (rd_cnt && !halt) begin
            cnt_lat_v <= !cnt_lat_v;
            cnt_lat   <= cnt;
        end
    end

    assign cnt_rd = (halt || !cnt_lat_v) ? cnt : cnt_lat; // R12

    ////////////////////////////////////////////////////////////////////////////////
    // Channels.

    logic [NCH-1:0]        ch_flag;
    logic [NCH-1:0]        ch_ie;
    logic [NCH-1:0][4:0]   csc_ctl;
    logic [NCH-1:0][15:0]  cv;
    logic [NCH-1:0][15:0]  cv_rd;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        tpw_chmode_e mode;
        logic [1:0]  els;
        logic [2:0]  pin_sync;
        logic        pin_prev;
        logic        cap_evt;
        logic        match_evt;
        logic [15:0] vbuf;
        logic        vb_hi_w;
        logic        vb_lo_w;
        logic        pend;
        logic        load_ok;
        logic        lat_v;
        logic [15:0] lat;
        logic [15:0] per_val;
        logic        edge_aligned_pwm_lvl;
        logic        centre_aligned_pwm_lvl;

        assign ch_ie[i] = csc_ctl[i][4];
        assign mode     = tpw_chan_mode(centre_aligned_pwm, csc_ctl[i][3:2]);
        assign els      = csc_ctl[i][1:0];

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                csc_ctl[i] <= CSC_CTL_RST;
            end else if (wr_csc[i]) begin
                csc_ctl[i] <= {wbyte[CSC_IE], wbyte[CSC_MS_LO +: 2], wbyte[CSC_ELS_LO +: 2]};
            end
        end

        // Pin passes three flops; pin_prev compares the second against the third.
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                pin_sync <= 3'h0;
            end else begin
                pin_sync <= {pin_sync[1:0], chan_in[i]};
            end
        end
        assign pin_prev = pin_sync[2];

        assign cap_evt = (mode == TPW_CAPTURE) &&
                         ((els[0] && pin_sync[1] && !pin_prev) ||
                          (els[1] && !pin_sync[1] && pin_prev)); // R7
        assign match_evt = cnt_moved && (mode != TPW_CAPTURE) && (cnt == cv[i]); // R8 R9 R10

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                vbuf    <= CNT_ZERO;
                vb_hi_w <= 1'b0;
                vb_lo_w <= 1'b0;
                pend    <= 1'b0;
            end else if (wr_csc[i]) begin
                vb_hi_w <= 1'b0; // R24
                vb_lo_w <= 1'b0;
                pend    <= 1'b0;
            end else if (mode == TPW_CAPTURE) begin
                vb_hi_w <= 1'b0; // R15
                vb_lo_w <= 1'b0;
                pend    <= 1'b0;
            end else if (wr_vh[i] || wr_vl[i]) begin
                if (wr_vh[i]) begin
                    vbuf[15:8] <= wbyte;
                end else begin
                    vbuf[7:0]  <= wbyte;
                end
                vb_hi_w <= wr_vh[i] ? !vb_lo_w : 1'b0;
                vb_lo_w <= wr_vl[i] ? !vb_hi_w : 1'b0;
                if ((wr_vh[i] && vb_lo_w) || (wr_vl[i] && vb_hi_w)) begin
                    pend <= 1'b1;
                end
            end else if (load_ok) begin
                pend <= 1'b0;
            end
        end

        // A load strobe that lands on a new byte write is skipped; pend stays set and the next load strobe takes it.
        always_comb begin
            if (clks == 2'h0) begin
                load_ok = pend; // R23
            end else if (mode == TPW_COMPARE) begin
                load_ok = pend && tick; // R16
            end else begin
                load_ok = pend && pwm_load; // R17
            end
        end

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                cv[i] <= CNT_ZERO;
            end else if (cap_evt) begin
                cv[i] <= cnt; // R7
            end else if (load_ok && !wr_csc[i] && !wr_vh[i] && !wr_vl[i]) begin
                cv[i] <= vbuf;
            end
        end

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                lat_v <= 1'b0;
                lat   <= CNT_ZERO;
            end else if (wr_csc[i] && halt) begin
                lat_v <= 1'b0; // R14
            end else if (rd_cv[i] && !halt) begin
                lat_v <= !lat_v;
                lat   <= cv[i];
            end
        end
        assign cv_rd[i] = (halt || !lat_v) ? cv[i] : lat; // R14

        // The centre duty is sampled at the top so a new setting waits a full period.
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                per_val <= CNT_ZERO;
            end else if (mode != TPW_CENTRE_PWM) begin
                per_val <= cv[i];
            end else if (tof_evt) begin
                per_val <= cv[i]; // R20 R21
            end
        end

        assign edge_aligned_pwm_lvl = cnt < cv[i];
        assign centre_aligned_pwm_lvl = (per_val != CNT_ZERO) && !per_val[15] &&
                          ((cnt < per_val) || (per_val >= mod)); // R18 R19

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                chan_out[i] <= 1'b0;
            end else if (mode == TPW_EDGE_PWM) begin
                chan_out[i] <= edge_aligned_pwm_lvl ^ els[0];
            end else if (mode == TPW_CENTRE_PWM) begin
                chan_out[i] <= centre_aligned_pwm_lvl ^ els[0];
            end else begin
                chan_out[i] <= 1'b0;
            end
        end

        tpw_flag u_ch_flag (
            .ref_clk (ref_clk),
            .nrst    (nrst),
            .set_evt (cap_evt || match_evt),
            .rd_hit  (rd_csc[i]),
            .wr_hit  (wr_csc[i]),
            .wr_val  (wbyte[CSC_FLAG]),
            .flag    (ch_flag[i])
        );

        AST_CAP_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst) // R15
            (mode == TPW_CAPTURE) && !cap_evt && (wr_vh[i] || wr_vl[i]) |=> $stable(cv[i]))
            else $error("capture channel value changed by write");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt and read data.

    assign irq = (ovf_flag && ovf_ie) || (|(ch_flag & ch_ie)); // R4

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == OFS_SC) begin
            prdata[7:0] = {ovf_flag, sc_ctl};
        end else if (paddr == OFS_CNTH) begin
            prdata[7:0] = cnt_rd[15:8];
        end else if (paddr == OFS_CNTL) begin
            prdata[7:0] = cnt_rd[7:0];
        end else if (paddr == OFS_MODH) begin
            prdata[7:0] = mod[15:8];
        end else if (paddr == OFS_MODL) begin
            prdata[7:0] = mod[7:0];
        end
        for (int i = 0; i < NCH; i++) begin
            if (ch_hit[i] && (paddr[3:2] == CH_SUB_SC)) begin
                prdata[7:0] = {ch_flag[i], csc_ctl[i], 2'h0};
            end else if (ch_hit[i] && (paddr[3:2] == CH_SUB_VH)) begin
                prdata[7:0] = cv_rd[i][15:8];
            end else if (ch_hit[i]) begin
                prdata[7:0] = cv_rd[i][7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_OVF_WRAP: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
        tick && !centre_aligned_pwm && !wr_cnt && (mod != MOD_RST) && (cnt == mod)
        |=> (cnt == CNT_ZERO) && ovf_flag)
        else $error("no overflow at modulo wrap");

    AST_OVF_FREE: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
        tick && !centre_aligned_pwm && !wr_cnt && (mod == MOD_RST) && (cnt == CNT_TOP)
        |=> (cnt == CNT_ZERO) && ovf_flag)
        else $error("no overflow at free-running wrap");

    AST_OVF_CENTRE_ALIGNED_PWM: assert property (@(posedge ref_clk) disable iff (!nrst) // R3
        tick && centre_aligned_pwm && !wr_cnt && cnt_up && (mod != MOD_RST) && (cnt == mod)
        |=> !cnt_up && ovf_flag)
        else $error("no overflow at centre reversal");

    AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
        $rose(ovf_flag) && ovf_ie |-> irq ##1 (irq || !ovf_flag || !ovf_ie))
        else $error("interrupt not following enabled flag");

    AST_CNT_WR_CLR: assert property (@(posedge ref_clk) disable iff (!nrst) // R11
        wr_cnt |=> (cnt == CNT_ZERO) && (div == 7'h00))
        else $error("counter write did not clear counter and divider");

    AST_CNT_HALT_RD: assert property (@(posedge ref_clk) disable iff (!nrst) // R12
        rd_cnt && halt && (paddr == OFS_CNTL) |-> (prdata[7:0] == cnt[7:0]))
        else $error("halted counter read not live");

    AST_MOD_SC_WR: assert property (@(posedge ref_clk) disable iff (!nrst) // R22
        wr_sc ##1 (!wr_modh && !wr_modl)[*2] ##1 wr_modl |=> $stable(mod))
        else $error("modulo latch not reset by control write");

endmodule : tpw_timer

//--- sim/timer_pwm_interrupt_and_update_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module timer_pwm_interrupt_and_update_tb;
    import tpw_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst    = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, irq, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  chan_out;
    logic [1:0]  pins = 2'b00;
    logic        halt = 1'b0;
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;
    always #50 ref_clk = ~ref_clk;
    tpw_apb_master tpw_apb_master_i (.ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    tpw_timer #(.NCH(2)) tpw_timer_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .background_debug_halt(halt),
        .chan_in(pins), .chan_out(chan_out), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        tpw_apb_master_i.xfer(1'b1, a, d, q, last_err);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] q;
        tpw_apb_master_i.xfer(1'b0, a, 8'h00, q, last_err);
        `CHK(q, e)
    endtask : rd
    task automatic wait_irq();
        int n;
        for (n = 0; n < 600 && irq !== 1'b1; n++) @(posedge ref_clk);
        `CHK(irq, 1'b1)
    endtask : wait_irq
    task automatic give_verdict();
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // The slow prescaler keeps overflows 512 cycles apart, so back-to-back clearing pairs never race them; the 530-cycle wait puts one between steps.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(OFS_SC, 8'h00);
        rd(OFS_CH_BASE, 8'h00);
        wr(OFS_MODH, 8'h00);
        wr(OFS_MODL, 8'h03);
        wr(OFS_SC, 8'h0F);
        repeat (600) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        rd(OFS_SC, 8'h8F);
        wr(OFS_SC, 8'h4F);
        rd(OFS_SC, 8'h4F);
        wait_irq();
        rd(OFS_SC, 8'hCF);
        repeat (530) @(posedge ref_clk);
        wr(OFS_SC, 8'h4F);
        rd(OFS_SC, 8'hCF);
        wr(OFS_SC, 8'hC0);
        rd(OFS_SC, 8'hC0);
        wr(OFS_SC, 8'h40);
        rd(OFS_SC, 8'h40);
        `CHK(irq, 1'b0)
        wr(OFS_SC, 8'h08);
        rd(OFS_CNTH, 8'h00);
        halt <= 1'b1;
        rd(OFS_CNTL, 8'h03);
        wr(OFS_MODH, 8'h00);
        wr(OFS_SC, 8'h00);
        halt <= 1'b0;
        wr(OFS_MODL, 8'h07);
        rd(OFS_MODL, 8'h03);
        rd(OFS_CNTL, 8'h03);
        rd(OFS_CNTH, 8'h00);
        wr(OFS_CNTH, 8'h00);
        rd(OFS_CNTH, 8'h00);
        rd(OFS_CNTL, 8'h00);
        wr(OFS_CH_BASE, 8'h50);
        wr(12'h024, 8'h00);
        wr(12'h028, 8'h02);
        rd(12'h024, 8'h00);
        rd(12'h028, 8'h02);
        wr(OFS_SC, 8'h08);
        wait_irq();
        wr(OFS_SC, 8'h00);
        rd(OFS_CH_BASE, 8'hD0);
        wr(OFS_CH_BASE, 8'h10);
        rd(OFS_CH_BASE, 8'h10);
        `CHK(irq, 1'b0)
        wr(OFS_CH_BASE, 8'h00);
        wr(12'h024, 8'h12);
        wr(12'h028, 8'h34);
        rd(12'h024, 8'h00);
        rd(12'h028, 8'h02);
        wr(OFS_CH_BASE, 8'h04);
        pins <= 2'b01;
        repeat (4) @(posedge ref_clk);
        rd(OFS_CH_BASE, 8'h84);
        rd(12'h024, 8'h00);
        rd(12'h028, 8'h03);
        wr(12'h030, 8'h10);
        wr(12'h034, 8'h00);
        wr(12'h038, 8'h03);
        wr(OFS_SC, 8'h20);
        rd(12'h034, 8'h00);
        rd(12'h038, 8'h03);
        `CHK(chan_out, 2'b10)
        rd(12'hFF0, 8'h00);
        `CHK(last_err, 1'b1)
        give_verdict();
    end
endmodule : timer_pwm_interrupt_and_update_tb

//--- sim/tpw_apb_master.sv
`timescale 1ns/1ns
module tpw_apb_master (
    // Clock.
    input  wire logic        ref_clk,
    // APB request.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    // APB answer.
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // Every transfer opens at least one edge after the last release, so no signal moves twice at one edge.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : tpw_apb_master
